// *** hw/pdc_pkg.sv ***
// constants, register map and state codes of the pci dma channel control block
// assumes a 10 MHz system clock and a 32-bit avalon-mm register slave
// Overview of operation
// - done interrupt requested on data transfer completion only while its enable is one
// - completed transfer with chain flag set fetches next descriptor from chain address
// - chain flag sets only when cpu write or fetch loads nonzero chain address
// - chain flag clears on channel reset or a zero chain address load
// - write of upper chain address half skips zero check, changes no flag
// - writing active one starts; stays clear when count zero and chain clear
// - nonzero chain address write sets active and starts transfer by itself
// - clearing active during a running transfer halts movement at once, return to idle follows after a short delay
// - channel clears active itself on normal end and on error stop
// - byte swap reverses bytes in each 32-bit word, else words pass unchanged
// - size 00 one 32-bit word, 01 one 64-bit, 10 four 64-bit, 11 reserved
// - direction one moves system bus to pci, zero pci to system bus
// - channel reset bit comes up one, holds channel logic reset until cleared
// - done status raised by chain complete with enable or transfer complete with enable
// - no data movement while the transfer count is zero
package pdc_pkg;
  // ***********************************************************
  // register map, byte addresses
  // ***********************************************************
  localparam logic [4:0] OFS_CONFIG = 5'h00;
  localparam logic [4:0] OFS_COUNT = 5'h04;
  localparam logic [4:0] OFS_CHAIN_LO = 5'h08;
  localparam logic [4:0] OFS_CHAIN_HI = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_MASK = 5'h14;
  // ***********************************************************
  // dma_channel_config fields
  // ***********************************************************
  localparam int CFG_RST = 0;
  localparam int CFG_DIR = 1;
  localparam int CFG_SIZE_LO = 2;
  localparam int CFG_SIZE_HI = 3;
  localparam int CFG_SWAP = 4;
  localparam int CFG_ACTIVE = 6;
  localparam int CFG_CHAIN = 7;
  localparam int CFG_XIE = 8;
  localparam int CFG_CIE = 9;
  // ***********************************************************
  // dma_channel_status fields, mask has the same layout
  // ***********************************************************
  localparam int ST_XDONE = 0;
  localparam int ST_CDONE = 1;
  localparam int ST_CABORT = 2;
  localparam int ST_DONEIRQ = 3;
  localparam int ST_W = 4;
  // ***********************************************************
  // transfer size codes and bytes per transaction
  // ***********************************************************
  localparam logic [1:0] SIZE_DW = 2'h0;
  localparam logic [1:0] SIZE_QW = 2'h1;
  localparam logic [1:0] SIZE_BURST = 2'h2;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] STEP_DW = 24'h000004;
  localparam logic [CNT_W-1:0] STEP_QW = 24'h000008;
  localparam logic [CNT_W-1:0] STEP_BURST = 24'h000020;
  localparam logic [CNT_W-1:0] CNT_MASK = 24'hFFFFFC;
  // ***********************************************************
  // halt delay after software drops active
  // ***********************************************************
  localparam int CLK_NS = 100;
  localparam int HALT_NS = 300;
  localparam int HALT_CYC_I = (HALT_NS / CLK_NS < 1) ? 1 : HALT_NS / CLK_NS;
  localparam logic [2:0] HALT_CYC = 3'(HALT_CYC_I);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_MOVE = 4'h2,
    ST_HALT = 4'h4,
    ST_FETCH = 4'h8
  } pdc_state_t;
endpackage

// *** hw/pdc_channel.sv ***
// pci dma channel control: config bits 9..0, count, chain address, irq status
// assumes a word mover outside that takes beats and a descriptor reader
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module pdc_channel
  import pdc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  output logic move_req_out,
  output logic xfer_direction_out,
  output logic [1:0] xfer_size_sel_out,
  input wire logic beat_ack_in,
  input wire logic [31:0] beat_data_in,
  output logic [31:0] beat_data_out,
  output logic beat_valid_out,
  input wire logic err_in,
  output logic desc_req_out,
  output logic [63:0] desc_addr_out,
  input wire logic desc_valid_in,
  input wire logic [CNT_W-1:0] desc_count_in,
  input wire logic [63:0] desc_next_in
);
  // ***********************************************************
  // registers
  // ***********************************************************
  pdc_state_t state_ff, nxt_state;
  logic acc_ff;
  logic [31:0] rdata_ff;
  logic channel_reset_bit_ff, xfer_direction_ff, word_byte_swap_ff;
  logic [1:0] xfer_size_sel_ff;
  logic xfer_active_ff, chain_follow_flag_ff;
  logic xfer_done_irq_en_ff, chain_done_irq_en_ff;
  logic [CNT_W-1:0] count_ff;
  logic [31:0] chain_lo_ff, chain_hi_ff;
  logic [ST_W-2:0] status_ff;
  logic [ST_W-1:0] mask_ff;
  logic [2:0] halt_cnt_ff;
  logic fetched_ff;
  logic [31:0] beat_data_ff;
  logic beat_valid_ff;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ***********************************************************
  // avalon slave: one wait cycle, write lands at the release edge
  // ***********************************************************
  logic req, wr_fire, wr_cfg, wr_cnt, wr_lo, wr_hi, wr_stat, wr_mask;
  logic [31:0] cfg_word, stat_word, cfg_new, lo_new, cnt_new;
  logic done_irq_status;
  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~acc_ff;
  assign wr_fire = avs_write_in & acc_ff;
  assign wr_cfg = wr_fire && avs_address_in == OFS_CONFIG;
  assign wr_cnt = wr_fire && avs_address_in == OFS_COUNT;
  assign wr_lo = wr_fire && avs_address_in == OFS_CHAIN_LO;
  assign wr_hi = wr_fire && avs_address_in == OFS_CHAIN_HI;
  assign wr_stat = wr_fire && avs_address_in == OFS_STATUS;
  assign wr_mask = wr_fire && avs_address_in == OFS_MASK;
  assign cfg_new = be_merge(cfg_word, avs_writedata_in, avs_byteenable_in);
  assign lo_new = be_merge(chain_lo_ff, avs_writedata_in, avs_byteenable_in);
  assign cnt_new = be_merge({8'h00, count_ff}, avs_writedata_in, avs_byteenable_in);
  assign done_irq_status = (status_ff[ST_CDONE] & chain_done_irq_en_ff)
                         | (status_ff[ST_XDONE] & xfer_done_irq_en_ff);
  always_comb
  begin
    cfg_word = '0;
    cfg_word[CFG_RST] = channel_reset_bit_ff;
    cfg_word[CFG_DIR] = xfer_direction_ff;
    cfg_word[CFG_SIZE_HI:CFG_SIZE_LO] = xfer_size_sel_ff;
    cfg_word[CFG_SWAP] = word_byte_swap_ff;
    cfg_word[CFG_ACTIVE] = xfer_active_ff;
    cfg_word[CFG_CHAIN] = chain_follow_flag_ff;
    cfg_word[CFG_XIE] = xfer_done_irq_en_ff;
    cfg_word[CFG_CIE] = chain_done_irq_en_ff;
    stat_word = {28'h0000000, done_irq_status, status_ff};
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      acc_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end
    else
    begin
      acc_ff <= req & ~acc_ff;
      if (avs_read_in && !acc_ff)
      begin
        case (avs_address_in)
          OFS_CONFIG: rdata_ff <= cfg_word;
          OFS_COUNT: rdata_ff <= {8'h00, count_ff};
          OFS_CHAIN_LO: rdata_ff <= chain_lo_ff;
          OFS_CHAIN_HI: rdata_ff <= chain_hi_ff;
          OFS_STATUS: rdata_ff <= stat_word;
          OFS_MASK: rdata_ff <= {28'h0000000, mask_ff};
          default: rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end
  assign avs_readdata_out = rdata_ff;

  // ***********************************************************
  // transfer engine decode
  // ***********************************************************
  logic [CNT_W-1:0] step;
  logic last_beat, size_bad, abort_evt, done_evt, start_ok;
  always_comb
  begin
    case (xfer_size_sel_ff)
      SIZE_DW: step = STEP_DW;
      SIZE_QW: step = STEP_QW;
      SIZE_BURST: step = STEP_BURST;
      default: step = STEP_DW;
    endcase
  end
  assign size_bad = xfer_size_sel_ff != SIZE_DW && xfer_size_sel_ff != SIZE_QW
                    && xfer_size_sel_ff != SIZE_BURST;
  assign last_beat = beat_ack_in && count_ff <= step;
  assign abort_evt = ((state_ff == ST_MOVE && xfer_active_ff) || state_ff == ST_FETCH)
                     && (err_in || (state_ff == ST_MOVE && size_bad));
  assign done_evt = !abort_evt && xfer_active_ff
                    && ((state_ff == ST_MOVE && last_beat && !chain_follow_flag_ff)
                     || (state_ff == ST_FETCH && desc_valid_in && desc_count_in == '0
                         && desc_next_in == 64'h0));
  assign start_ok = count_ff != '0 || chain_follow_flag_ff;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (xfer_active_ff)
        begin
          nxt_state = (count_ff != '0) ? ST_MOVE : ST_FETCH;
        end
      end
      ST_MOVE:
      begin
        if (!xfer_active_ff)
        begin
          nxt_state = ST_HALT;
        end
        else if (abort_evt || done_evt)
        begin
          nxt_state = ST_IDLE;
        end
        else if (last_beat)
        begin
          nxt_state = ST_FETCH;
        end
      end
      ST_HALT:
      begin
        if (halt_cnt_ff == HALT_CYC)
        begin
          nxt_state = ST_IDLE;
        end
      end
      ST_FETCH:
      begin
        if (abort_evt || done_evt)
        begin
          nxt_state = ST_IDLE;
        end
        else if (desc_valid_in)
        begin
          nxt_state = (desc_count_in != '0) ? ST_MOVE : ST_FETCH;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // channel reset holds every state machine idle
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff <= ST_IDLE;
      halt_cnt_ff <= 3'h0;
      fetched_ff <= 1'b0;
    end
    else if (channel_reset_bit_ff)
    begin
      state_ff <= ST_IDLE;
      halt_cnt_ff <= 3'h0;
      fetched_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      halt_cnt_ff <= (state_ff == ST_HALT) ? halt_cnt_ff + 3'h1 : 3'h0;
      if (state_ff == ST_IDLE)
      begin
        fetched_ff <= 1'b0;
      end
      else if (state_ff == ST_FETCH && desc_valid_in)
      begin
        fetched_ff <= 1'b1;
      end
    end
  end

  // ***********************************************************
  // control register bits
  // ***********************************************************
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      channel_reset_bit_ff <= 1'b1;
      xfer_direction_ff <= 1'b0;
      xfer_size_sel_ff <= 2'h0;
      word_byte_swap_ff <= 1'b0;
      xfer_done_irq_en_ff <= 1'b0;
      chain_done_irq_en_ff <= 1'b0;
    end
    else if (wr_cfg)
    begin
      channel_reset_bit_ff <= cfg_new[CFG_RST];
      xfer_direction_ff <= cfg_new[CFG_DIR];
      xfer_size_sel_ff <= cfg_new[CFG_SIZE_HI:CFG_SIZE_LO];
      word_byte_swap_ff <= cfg_new[CFG_SWAP];
      xfer_done_irq_en_ff <= cfg_new[CFG_XIE];
      chain_done_irq_en_ff <= cfg_new[CFG_CIE];
    end
  end

  // transfer active: software start, address start, hardware clear
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      xfer_active_ff <= 1'b0;
    end
    else if (channel_reset_bit_ff)
    begin
      xfer_active_ff <= 1'b0;
    end
    else if (wr_lo && {chain_hi_ff, lo_new} != 64'h0)
    begin
      xfer_active_ff <= 1'b1;
    end
    else if (wr_cfg && cfg_new[CFG_ACTIVE])
    begin
      xfer_active_ff <= start_ok;
    end
    else if (wr_cfg)
    begin
      xfer_active_ff <= 1'b0;
    end
    else if (abort_evt || done_evt)
    begin
      xfer_active_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      chain_follow_flag_ff <= 1'b0;
    end
    else if (channel_reset_bit_ff)
    begin
      chain_follow_flag_ff <= 1'b0;
    end
    else if (wr_lo)
    begin
      chain_follow_flag_ff <= {chain_hi_ff, lo_new} != 64'h0;
    end
    else if (state_ff == ST_FETCH && desc_valid_in)
    begin
      chain_follow_flag_ff <= desc_next_in != 64'h0;
    end
  end

  // address and count keep their value across reset of the channel
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      chain_lo_ff <= 32'h00000000;
      chain_hi_ff <= 32'h00000000;
      count_ff <= '0;
    end
    else
    begin
      if (wr_lo)
      begin
        chain_lo_ff <= lo_new;
      end
      else if (state_ff == ST_FETCH && desc_valid_in)
      begin
        chain_lo_ff <= desc_next_in[31:0];
      end
      if (wr_hi)
      begin
        chain_hi_ff <= be_merge(chain_hi_ff, avs_writedata_in, avs_byteenable_in);
      end
      else if (state_ff == ST_FETCH && desc_valid_in)
      begin
        chain_hi_ff <= desc_next_in[63:32];
      end
      if (wr_cnt)
      begin
        count_ff <= cnt_new[CNT_W-1:0] & CNT_MASK;
      end
      else if (state_ff == ST_FETCH && desc_valid_in)
      begin
        count_ff <= desc_count_in & CNT_MASK;
      end
      else if (state_ff == ST_MOVE && xfer_active_ff && beat_ack_in)
      begin
        count_ff <= last_beat ? '0 : count_ff - step;
      end
    end
  end

  // ***********************************************************
  // data path
  // ***********************************************************
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      beat_data_ff <= 32'h00000000;
      beat_valid_ff <= 1'b0;
    end
    else
    begin
      // beats taken only while counted, so a halting channel passes none on
      beat_valid_ff <= state_ff == ST_MOVE && xfer_active_ff && beat_ack_in;
      if (state_ff == ST_MOVE && xfer_active_ff && beat_ack_in)
      begin
        beat_data_ff <= word_byte_swap_ff ? {beat_data_in[7:0], beat_data_in[15:8],
                        beat_data_in[23:16], beat_data_in[31:24]} : beat_data_in;
      end
    end
  end
  assign beat_data_out = beat_data_ff;
  assign beat_valid_out = beat_valid_ff;
  assign move_req_out = state_ff == ST_MOVE && xfer_active_ff;
  assign xfer_direction_out = xfer_direction_ff;
  assign xfer_size_sel_out = xfer_size_sel_ff;
  assign desc_req_out = state_ff == ST_FETCH;
  assign desc_addr_out = {chain_hi_ff, chain_lo_ff};

  // ***********************************************************
  // sticky status, mask and interrupt
  // ***********************************************************
  logic [ST_W-2:0] stat_set;
  always_comb
  begin
    stat_set = '0;
    stat_set[ST_XDONE] = !abort_evt && state_ff == ST_MOVE && xfer_active_ff && last_beat;
    stat_set[ST_CDONE] = done_evt && fetched_ff;
    stat_set[ST_CABORT] = abort_evt;
  end
  // set wins over a simultaneous write-one clear
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      status_ff <= '0;
      mask_ff <= '0;
    end
    else
    begin
      status_ff <= (status_ff & ~(wr_stat ? avs_writedata_in[ST_W-2:0] : '0)) | stat_set;
      if (wr_mask)
      begin
        mask_ff <= avs_writedata_in[ST_W-1:0];
      end
    end
  end
  assign irq_out = |({done_irq_status, status_ff} & mask_ff);

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  chk_done_irq_gate: assert property ($rose(status_ff[ST_XDONE]) && !wr_cfg
    |-> done_irq_status == xfer_done_irq_en_ff || status_ff[ST_CDONE])
    else $error("done status does not follow its enable");
  chk_chain_fetch: assert property (state_ff == ST_MOVE && last_beat && xfer_active_ff
    && chain_follow_flag_ff && !abort_evt && !channel_reset_bit_ff |=> desc_req_out)
    else $error("no descriptor fetch after chained transfer");
  chk_chain_set: assert property ($rose(chain_follow_flag_ff)
    |-> $past(wr_lo) || $past(desc_valid_in))
    else $error("chain flag set without address load");
  chk_chain_clr: assert property (channel_reset_bit_ff |=> !chain_follow_flag_ff)
    else $error("chain flag survives channel reset");
  chk_upper_write: assert property (wr_hi && state_ff == ST_IDLE
    |=> $stable(chain_follow_flag_ff) && $stable(xfer_active_ff))
    else $error("upper address write changed a flag");
  chk_start_refused: assert property (wr_cfg && cfg_new[CFG_ACTIVE] && count_ff == '0
    && !chain_follow_flag_ff |=> !xfer_active_ff)
    else $error("active set with zero count and no chain");
  chk_addr_start: assert property (wr_lo && {chain_hi_ff, lo_new} != 64'h0
    && !channel_reset_bit_ff |=> xfer_active_ff ##1 state_ff != ST_IDLE)
    else $error("chain address write did not start");
  chk_halt_delay: assert property ($rose(state_ff == ST_HALT)
    |-> !move_req_out throughout (##[1:5] state_ff == ST_IDLE))
    else $error("halt did not end in time");
  chk_error_stop: assert property (abort_evt && !wr_lo |=> !xfer_active_ff)
    else $error("active survives an error");
  chk_byte_swap: assert property (move_req_out && beat_ack_in && word_byte_swap_ff
    |=> beat_data_out[7:0] == $past(beat_data_in[31:24]) && beat_valid_out)
    else $error("word not byte swapped");
  chk_channel_reset_bit_idle: assert property (channel_reset_bit_ff |=> state_ff == ST_IDLE)
    else $error("engine runs under channel reset");
  chk_no_zero_move: assert property (move_req_out |-> count_ff != '0)
    else $error("movement with zero count");
endmodule // pdc_channel

// *** verif/pdc_far_model.sv ***
// far side model: word mover and descriptor reader facing the channel
// assumes level requests from the channel and one-cycle answers from here
`timescale 1ns/1ps
module pdc_far_model
  import pdc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic move_req_in,
  input wire logic desc_req_in,
  input wire logic [CNT_W-1:0] next_count_in,
  output logic beat_ack_out,
  output logic [31:0] beat_data_out,
  output logic desc_valid_out,
  output logic [CNT_W-1:0] desc_count_out,
  output logic [63:0] desc_next_out
);
  logic [2:0] wait_ff;
  // ***********************************************************
  // answers; slow mode stalls six cycles before each one
  // ***********************************************************
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wait_ff <= 3'h0;
      beat_ack_out <= 1'b0;
      desc_valid_out <= 1'b0;
      beat_data_out <= 32'h0;
    end
    else
    begin
      beat_ack_out <= 1'b0;
      desc_valid_out <= 1'b0;
      // idle data never repeats the last word
      beat_data_out <= ~beat_data_out;
      if ((move_req_in && !beat_ack_out) || (desc_req_in && !desc_valid_out))
      begin
        if (wait_ff >= (slow_in ? 3'h6 : 3'h0))
        begin
          wait_ff <= 3'h0;
          beat_ack_out <= move_req_in;
          desc_valid_out <= desc_req_in;
          if (move_req_in)
            beat_data_out <= $urandom;
        end
        else
          wait_ff <= wait_ff + 3'h1;
      end
    end
  end
  assign desc_count_out = next_count_in;
  // chain ends after one descriptor
  assign desc_next_out = 64'h0;
endmodule // pdc_far_model

// *** verif/pci_dma_channel_control_tb.sv ***
// self-checking bench of the dma channel control block
// assumes the far side model and a 10 MHz clock
`timescale 1ns/1ps
module pci_dma_channel_control_tb;
  import pdc_pkg::*;
  logic clk_sys_in, rst_in, avs_read_in, avs_write_in, err_in, slow, swap_en;
  logic [4:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, beat_data_in, beat_data_out, rd;
  logic avs_waitrequest_out, irq_out, move_req_out, xfer_direction_out, beat_ack_in;
  logic beat_valid_out, desc_req_out, desc_valid_in;
  logic [1:0] xfer_size_sel_out;
  logic [63:0] desc_addr_out, desc_next_in;
  logic [CNT_W-1:0] desc_count_in, next_count;
  logic [31:0] exp_q[$];
  int n_errors, checks_done, n_beats, n;

  pdc_channel i_pdc_channel(.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
    .move_req_out(move_req_out), .xfer_direction_out(xfer_direction_out),
    .xfer_size_sel_out(xfer_size_sel_out), .beat_ack_in(beat_ack_in),
    .beat_data_in(beat_data_in), .beat_data_out(beat_data_out),
    .beat_valid_out(beat_valid_out), .err_in(err_in), .desc_req_out(desc_req_out),
    .desc_addr_out(desc_addr_out), .desc_valid_in(desc_valid_in),
    .desc_count_in(desc_count_in), .desc_next_in(desc_next_in));
  pdc_far_model i_pdc_far_model(.clk_sys_in(clk_sys_in), .rst_in(rst_in), .slow_in(slow),
    .move_req_in(move_req_out), .desc_req_in(desc_req_out), .next_count_in(next_count),
    .beat_ack_out(beat_ack_in), .beat_data_out(beat_data_in),
    .desc_valid_out(desc_valid_in), .desc_count_out(desc_count_in),
    .desc_next_out(desc_next_in));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // ***********************************************************
  // expectation helpers and checks
  // ***********************************************************
  function automatic logic [31:0] word_byte_swap(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  function automatic int step_of(input logic [1:0] sz);
    return (sz == 2'h0) ? 4 : (sz == 2'h1) ? 8 : 32;
  endfunction
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic hang(input string what);
    n_errors++;
    $display("[ERR] %0t timeout %s", $time, what);
    summarize();
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    k = 0;
    do
    begin
      @(posedge clk_sys_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 50);
    if (k >= 50)
      hang("bus");
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    do
    begin
      bus(1'b0, OFS_CONFIG, 32'h0);
      k++;
    end while (rd[CFG_ACTIVE] !== 1'b0 && k < 300);
    if (k >= 300)
      hang("active");
  endtask
  task automatic wait_move();
    int k;
    k = 0;
    while (move_req_out !== 1'b1 && k < 50)
    begin
      @(posedge clk_sys_in);
      k++;
    end
    if (k >= 50)
      hang("move");
  endtask
  task automatic run_xfer(input logic [1:0] sz, input logic dir, input logic xie,
                          input logic [CNT_W-1:0] cnt);
    logic [31:0] cfg;
    cfg = 32'h0;
    cfg[CFG_XIE] = xie;
    cfg[CFG_SWAP] = swap_en;
    cfg[CFG_SIZE_HI:CFG_SIZE_LO] = sz;
    cfg[CFG_DIR] = dir;
    cfg[CFG_ACTIVE] = 1'b1;
    n_beats = 0;
    bus(1'b1, OFS_COUNT, {8'h00, cnt});
    bus(1'b1, OFS_CONFIG, cfg);
    @(negedge clk_sys_in);
    chk({29'h0, xfer_direction_out, xfer_size_sel_out}, {29'h0, dir, sz}, "dir size");
    wait_idle();
    chk(n_beats, cnt / step_of(sz), "beat count");
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_XDONE], 1'b1, "xfer done");
    @(negedge clk_sys_in);
    chk(irq_out, xie, "done irq");
    bus(1'b1, OFS_STATUS, 32'h7);
    @(negedge clk_sys_in);
    chk(irq_out, 1'b0, "irq cleared");
  endtask
  // ***********************************************************
  // beat monitor: data, order and swap
  // ***********************************************************
  always @(posedge clk_sys_in)
  begin
    if (beat_valid_out === 1'b1)
    begin
      n_beats++;
      chk(beat_data_out, exp_q.pop_front(), "beat data");
    end
    if (beat_ack_in && move_req_out)
      exp_q.push_back(swap_en ? word_byte_swap(beat_data_in) : beat_data_in);
    if (desc_req_out === 1'b1 && desc_valid_in === 1'b1)
    begin
      chk(desc_addr_out[31:0], 32'h00000100, "descriptor address lo");
      chk(desc_addr_out[63:32], 32'h00000000, "descriptor address hi");
    end
  end
  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial
  begin
    {avs_read_in, avs_write_in, err_in, slow, swap_en} = 5'h00;
    avs_address_in = 5'h00;
    avs_writedata_in = 32'h0;
    // two bursts at the size left by the last random transfer
    next_count = 24'h000040;
    rst_in = 1'b1;
    void'($urandom(32421));
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk(rd, 32'h00000001, "config reset");
    bus(1'b0, 5'h18, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    bus(1'b1, OFS_CONFIG, 32'h0);
    bus(1'b1, OFS_MASK, 32'h8);
    bus(1'b1, OFS_COUNT, 32'h0);
    bus(1'b1, OFS_CONFIG, 32'h40);
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk(rd[CFG_ACTIVE], 1'b0, "active with zero count");
    @(negedge clk_sys_in);
    chk(move_req_out, 1'b0, "no move at zero count");
    for (n = 0; n < 6; n++)
    begin
      slow = $urandom % 2;
      swap_en = $urandom % 2;
      run_xfer(n % 3, $urandom % 2, n > 0, 24'(step_of(n % 3) * (1 + $urandom % 3)));
    end
    slow = 1'b1;
    bus(1'b1, OFS_CHAIN_HI, 32'h1);
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk(rd[CFG_CHAIN:CFG_ACTIVE], 2'h0, "upper half write");
    bus(1'b1, OFS_CHAIN_HI, 32'h0);
    n_beats = 0;
    bus(1'b1, OFS_CHAIN_LO, 32'h100);
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk(rd[CFG_CHAIN:CFG_ACTIVE], 2'h3, "chain start");
    wait_idle();
    chk(n_beats, 2, "chained beats");
    chk(rd[CFG_CHAIN], 1'b0, "chain flag after zero next");
    bus(1'b1, OFS_STATUS, 32'h7);
    slow = 1'b0;
    swap_en = 1'b0;
    bus(1'b1, OFS_COUNT, 32'h40);
    bus(1'b1, OFS_CONFIG, 32'h40);
    wait_move();
    err_in <= 1'b1;
    @(posedge clk_sys_in);
    err_in <= 1'b0;
    wait_idle();
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_CABORT], 1'b1, "error stop");
    bus(1'b1, OFS_STATUS, 32'h7);
    bus(1'b1, OFS_COUNT, 32'h40);
    bus(1'b1, OFS_CONFIG, 32'h4C);
    wait_idle();
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_CABORT], 1'b1, "reserved size stop");
    bus(1'b1, OFS_COUNT, 32'h400);
    bus(1'b1, OFS_CONFIG, 32'h40);
    wait_move();
    bus(1'b1, OFS_CONFIG, 32'h0);
    for (n = 0; n < 8 && move_req_out !== 1'b0; n++)
      @(posedge clk_sys_in);
    chk(move_req_out, 1'b0, "halt after clear");
    wait_idle();
    bus(1'b1, OFS_CONFIG, 32'h1);
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk(rd, 32'h00000001, "channel reset");
    summarize();
  end
endmodule // pci_dma_channel_control_tb
